/* File: rtl/nlcb_pkg.sv */
// Constants and carrier types for the nonlinearity coefficient bank.
// Assumes one 24-bit register word per address on the internal register port.
package nlcb_pkg;
    localparam int unsigned         NLCB_NUM_REGS  = 5;
    localparam int unsigned         NLCB_DATA_W    = 24;
    localparam int unsigned         NLCB_ADDR_W    = 8;
    localparam int unsigned         NLCB_COEFF_W   = 16;
    localparam int unsigned         NLCB_BYTE_W    = 8;

    // Register addresses
    localparam logic [7:0]          NLCB_ADDR_AE   = 8'hAE;
    localparam logic [7:0]          NLCB_ADDR_AF   = 8'hAF;
    localparam logic [7:0]          NLCB_ADDR_B0   = 8'hB0;
    localparam logic [7:0]          NLCB_ADDR_B1   = 8'hB1;
    localparam logic [7:0]          NLCB_ADDR_B2   = 8'hB2;
    localparam logic [4:0][7:0]     NLCB_ADDR_TAB  = {NLCB_ADDR_B2, NLCB_ADDR_B1, NLCB_ADDR_B0,
                                                      NLCB_ADDR_AF, NLCB_ADDR_AE};

    // Indices into the register array
    localparam int unsigned         NLCB_IDX_AE    = 0;
    localparam int unsigned         NLCB_IDX_AF    = 1;
    localparam int unsigned         NLCB_IDX_B0    = 2;
    localparam int unsigned         NLCB_IDX_B1    = 3;
    localparam int unsigned         NLCB_IDX_B2    = 4;

    // Field positions
    localparam int unsigned         NLCB_UP_MSB    = 23;
    localparam int unsigned         NLCB_UP_LSB    = 16;
    localparam int unsigned         NLCB_LO_MSB    = 15;
    localparam int unsigned         NLCB_LO_LSB    = 0;

    localparam logic [23:0]         NLCB_RST_VAL   = 24'h00_0000;
    localparam logic [15:0]         NLCB_COEFF_RST = 16'h0000;

    typedef logic [NLCB_DATA_W-1:0] nlcb_word_t;

    typedef struct packed {
        logic [15:0] cubic_coeff_ch0_high;
        logic [15:0] quadratic_coeff_ch1_high;
        logic [15:0] quartic_coeff_ch1_high;
        logic [15:0] quadratic_coeff_ch2_low;
        logic [15:0] quartic_coeff_ch2_low;
        logic [15:0] quadratic_coeff_ch2_high;
        logic [15:0] quartic_coeff_ch2_high;
    } nlcb_coeff_t;

    typedef struct packed {
        logic [15:0] quadratic;
        logic [15:0] quartic;
    } nlcb_pair_t;

    typedef struct packed {
        logic [15:0] cubic_ch0;
        nlcb_pair_t  ch1;
        nlcb_pair_t  ch2;
    } nlcb_sel_t;
endpackage

/* File: rtl/nlcb_coeff_sel.sv */
// Per-channel coefficient selection by current setting.
// Assumes the current-setting flags come from logic on mclk.
`timescale 1ns/1ps
module nlcb_coeff_sel (
    input  wire logic                 mclk,
    input  wire logic                 rst_n,
    input  wire logic                 ce,
    input  wire nlcb_pkg::nlcb_coeff_t coeff,
    input  wire logic                 ch2_high_sel,
    output nlcb_pkg::nlcb_sel_t       sel_q
);
    nlcb_pkg::nlcb_sel_t sel_d;

    ////////////////////////////////////////////////////////////////////////////
    // Current-based selection
    // Only channel two has both sets in this bank; others pass unchanged
    always_comb begin
        sel_d               = sel_q;
        if (ce) begin
            sel_d.cubic_ch0     = coeff.cubic_coeff_ch0_high;
            sel_d.ch1.quadratic = coeff.quadratic_coeff_ch1_high;
            sel_d.ch1.quartic   = coeff.quartic_coeff_ch1_high;
            if (ch2_high_sel) begin
                sel_d.ch2.quadratic = coeff.quadratic_coeff_ch2_high;
                sel_d.ch2.quartic   = coeff.quartic_coeff_ch2_high;
            end else begin
                sel_d.ch2.quadratic = coeff.quadratic_coeff_ch2_low;
                sel_d.ch2.quartic   = coeff.quartic_coeff_ch2_low;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sel_q <= '0;
        end else begin
            sel_q <= sel_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    AST_CH2_SELECT: assert property (@(posedge mclk) disable iff (!rst_n)
        ce |=> sel_q.ch2.quartic == ($past(ch2_high_sel) ? $past(coeff.quartic_coeff_ch2_high)
                                                        : $past(coeff.quartic_coeff_ch2_low)))
        else $error("Channel two quartic coefficient not from the selected current set");
endmodule

/* File: rtl/nlcb_bank.sv */
// Nonlinearity correction coefficient bank, registers AE to B2.
// Assumes the serial control logic presents register accesses on mclk as
// single-cycle read and write strobes with an 8-bit address.
`timescale 1ns/1ps

module nlcb_bank (
    input  wire logic                 mclk,
    input  wire logic                 rst_n,
    input  wire logic                 ce,
    input  wire logic                 reg_wr_en,
    input  wire logic                 reg_rd_en,
    input  wire logic [7:0]           reg_addr,
    input  wire logic [23:0]          reg_wdata,
    output logic      [23:0]          reg_rdata_q,
    output logic                      reg_rvalid_q,
    output logic                      reg_hit_q,
    input  wire logic                 ch2_high_sel,
    output nlcb_pkg::nlcb_coeff_t     coeff_q,
    output nlcb_pkg::nlcb_sel_t       sel_q
);
    localparam int unsigned N   = nlcb_pkg::NLCB_NUM_REGS;
    localparam int unsigned UM  = nlcb_pkg::NLCB_UP_MSB;
    localparam int unsigned UL  = nlcb_pkg::NLCB_UP_LSB;
    localparam int unsigned LM  = nlcb_pkg::NLCB_LO_MSB;
    localparam int unsigned LL  = nlcb_pkg::NLCB_LO_LSB;

    nlcb_pkg::nlcb_word_t   regs_q [N];
    nlcb_pkg::nlcb_word_t   regs_d [N];
    logic [N-1:0]           sel_hit;
    logic [23:0]            rdata_d;
    logic                   rvalid_d;
    logic                   hit_d;

    ////////////////////////////////////////////////////////////////////////////
    // Register storage, one entry per address
    for (genvar i = 0; i < N; i++) begin : g_reg
        assign sel_hit[i] = (reg_addr == nlcb_pkg::NLCB_ADDR_TAB[i]);

        always_comb begin
            regs_d[i] = regs_q[i];
            if (ce && reg_wr_en && sel_hit[i]) begin
                regs_d[i] = reg_wdata;
            end
        end

        always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                regs_q[i] <= nlcb_pkg::NLCB_RST_VAL;
            end else begin
                regs_q[i] <= regs_d[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port; unmapped addresses answer zero with hit low
    always_comb begin
        rdata_d  = reg_rdata_q;
        rvalid_d = 1'b0;
        hit_d    = reg_hit_q;
        if (ce && reg_rd_en) begin
            rvalid_d = 1'b1;
            hit_d    = 1'b1;
            if (reg_addr == nlcb_pkg::NLCB_ADDR_AE) begin
                rdata_d = regs_q[nlcb_pkg::NLCB_IDX_AE];
            end else if (reg_addr == nlcb_pkg::NLCB_ADDR_AF) begin
                rdata_d = regs_q[nlcb_pkg::NLCB_IDX_AF];
            end else if (reg_addr == nlcb_pkg::NLCB_ADDR_B0) begin
                rdata_d = regs_q[nlcb_pkg::NLCB_IDX_B0];
            end else if (reg_addr == nlcb_pkg::NLCB_ADDR_B1) begin
                rdata_d = regs_q[nlcb_pkg::NLCB_IDX_B1];
            end else if (reg_addr == nlcb_pkg::NLCB_ADDR_B2) begin
                rdata_d = regs_q[nlcb_pkg::NLCB_IDX_B2];
            end else begin
                rdata_d = nlcb_pkg::NLCB_RST_VAL;
                hit_d   = 1'b0;
            end
        end
    end

    // rvalid is a pulse; a low ce also freezes it, so it may stand while ce is low
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_q  <= nlcb_pkg::NLCB_RST_VAL;
            reg_rvalid_q <= 1'b0;
            reg_hit_q    <= 1'b0;
        end else if (ce) begin
            reg_rdata_q  <= rdata_d;
            reg_rvalid_q <= rvalid_d;
            reg_hit_q    <= hit_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Coefficient views taken straight from the stored words
    always_comb begin
        // Quartic split across AE and AF
        coeff_q.quartic_coeff_ch1_high   = {regs_q[nlcb_pkg::NLCB_IDX_AE][UM:UL],
                                            regs_q[nlcb_pkg::NLCB_IDX_AF][UM:UL]};
        coeff_q.quadratic_coeff_ch1_high = regs_q[nlcb_pkg::NLCB_IDX_AE][LM:LL];
        coeff_q.quadratic_coeff_ch2_low  = regs_q[nlcb_pkg::NLCB_IDX_AF][LM:LL];
        // Quartic split across B0 and B1
        coeff_q.quartic_coeff_ch2_low    = {regs_q[nlcb_pkg::NLCB_IDX_B0][UM:UL],
                                            regs_q[nlcb_pkg::NLCB_IDX_B1][UM:UL]};
        coeff_q.quadratic_coeff_ch2_high = regs_q[nlcb_pkg::NLCB_IDX_B0][LM:LL];
        coeff_q.cubic_coeff_ch0_high     = regs_q[nlcb_pkg::NLCB_IDX_B1][LM:LL];
        coeff_q.quartic_coeff_ch2_high   = regs_q[nlcb_pkg::NLCB_IDX_B2][LM:LL];
    end

    nlcb_coeff_sel u_sel (
        .mclk         (mclk),
        .rst_n        (rst_n),
        .ce           (ce),
        .coeff        (coeff_q),
        .ch2_high_sel (ch2_high_sel),
        .sel_q        (sel_q)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_wr_ae;
        ce && reg_wr_en && reg_addr == nlcb_pkg::NLCB_ADDR_AE;
    endsequence

    sequence s_wr_af;
        ce && reg_wr_en && reg_addr == nlcb_pkg::NLCB_ADDR_AF;
    endsequence

    sequence s_wr_b0;
        ce && reg_wr_en && reg_addr == nlcb_pkg::NLCB_ADDR_B0;
    endsequence

    sequence s_wr_b1;
        ce && reg_wr_en && reg_addr == nlcb_pkg::NLCB_ADDR_B1;
    endsequence

    sequence s_wr_b2;
        ce && reg_wr_en && reg_addr == nlcb_pkg::NLCB_ADDR_B2;
    endsequence

    AST_CH1_QUARTIC_UP: assert property (@(posedge mclk) disable iff (!rst_n)
        s_wr_ae |=> coeff_q.quartic_coeff_ch1_high[15:8] == $past(reg_wdata[23:16]))
        else $error("Channel one quartic upper byte not taken from AE");

    AST_CH1_QUARTIC_LO: assert property (@(posedge mclk) disable iff (!rst_n)
        s_wr_af |=> coeff_q.quartic_coeff_ch1_high[7:0] == $past(reg_wdata[23:16]))
        else $error("Channel one quartic lower byte not taken from AF");

    AST_CH1_QUADRATIC: assert property (@(posedge mclk) disable iff (!rst_n)
        s_wr_ae |=> coeff_q.quadratic_coeff_ch1_high == $past(reg_wdata[15:0]))
        else $error("Channel one quadratic not taken from AE");

    AST_CH2_LO_QUAD: assert property (@(posedge mclk) disable iff (!rst_n)
        s_wr_af |=> coeff_q.quadratic_coeff_ch2_low == $past(reg_wdata[15:0]))
        else $error("Channel two low quadratic not taken from AF");

    AST_CH2_LO_QUARTIC: assert property (@(posedge mclk) disable iff (!rst_n)
        s_wr_b0 ##1 s_wr_b1 |=> coeff_q.quartic_coeff_ch2_low
            == {$past(reg_wdata[23:16], 2), $past(reg_wdata[23:16])})
        else $error("Channel two low quartic bytes misplaced");

    AST_CH2_HI_QUAD: assert property (@(posedge mclk) disable iff (!rst_n)
        s_wr_b0 |=> coeff_q.quadratic_coeff_ch2_high == $past(reg_wdata[15:0]))
        else $error("Channel two high quadratic not taken from B0");

    AST_CH0_CUBIC: assert property (@(posedge mclk) disable iff (!rst_n)
        s_wr_b1 |=> coeff_q.cubic_coeff_ch0_high == $past(reg_wdata[15:0]))
        else $error("Channel zero cubic not taken from B1");

    AST_B2_READBACK: assert property (@(posedge mclk) disable iff (!rst_n)
        s_wr_b2 ##1 (ce && reg_rd_en && !reg_wr_en && reg_addr == nlcb_pkg::NLCB_ADDR_B2)
            |=> reg_rvalid_q && reg_hit_q && reg_rdata_q == $past(reg_wdata, 2))
        else $error("B2 did not read back the full written word");

    AST_CH2_HI_QUARTIC: assert property (@(posedge mclk) disable iff (!rst_n)
        s_wr_b2 |=> coeff_q.quartic_coeff_ch2_high == $past(reg_wdata[15:0]))
        else $error("Channel two high quartic not taken from B2");

    AST_HOLD_NO_WRITE: assert property (@(posedge mclk) disable iff (!rst_n)
        !(ce && reg_wr_en) |=> $stable(coeff_q))
        else $error("Coefficients changed without a write");

    AST_UNMAPPED_READ: assert property (@(posedge mclk) disable iff (!rst_n)
        (ce && reg_rd_en && !(|sel_hit)) |=> reg_rvalid_q && !reg_hit_q
            && reg_rdata_q == nlcb_pkg::NLCB_RST_VAL)
        else $error("Unmapped read did not answer zero with hit low");
endmodule

/* File: dv/nlcb_bank_test.sv */
// Self-checking bench for the nonlinearity coefficient bank.
// Assumes the bank alone on mclk, driven through its strobe port with ce mostly high.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end

module nlcb_bank_test;
    typedef struct packed {
        logic [7:0]  addr;
        logic [23:0] wdata;
        logic [23:0] rdata;
        logic        hit;
    } nlcb_row_t;

    logic                  mclk;
    logic                  rst_n;
    logic                  ce;
    logic                  reg_wr_en;
    logic                  reg_rd_en;
    logic [7:0]            reg_addr;
    logic [23:0]           reg_wdata;
    logic [23:0]           reg_rdata_q;
    logic                  reg_rvalid_q;
    logic                  reg_hit_q;
    logic                  ch2_high_sel;
    nlcb_pkg::nlcb_coeff_t coeff_q;
    nlcb_pkg::nlcb_sel_t   sel_q;
    int                    n_fail;
    int                    n_compared;
    // Unmapped rows sit just outside the bank so aliasing would corrupt a neighbour
    nlcb_row_t             rows [7] = '{
        '{8'hAE, 24'h12_3456, 24'h12_3456, 1'b1},
        '{8'hAF, 24'h78_9ABC, 24'h78_9ABC, 1'b1},
        '{8'hB0, 24'hDE_F012, 24'hDE_F012, 1'b1},
        '{8'hB1, 24'h34_5678, 24'h34_5678, 1'b1},
        '{8'hB2, 24'h00_4321, 24'h00_4321, 1'b1}, // Reserved byte written as zero
        '{8'hAD, 24'hFF_FFFF, 24'h00_0000, 1'b0},
        '{8'hB3, 24'hFF_FFFF, 24'h00_0000, 1'b0}};

    nlcb_bank nlcb_bank_inst (
        .mclk         (mclk),
        .rst_n        (rst_n),
        .ce           (ce),
        .reg_wr_en    (reg_wr_en),
        .reg_rd_en    (reg_rd_en),
        .reg_addr     (reg_addr),
        .reg_wdata    (reg_wdata),
        .reg_rdata_q  (reg_rdata_q),
        .reg_rvalid_q (reg_rvalid_q),
        .reg_hit_q    (reg_hit_q),
        .ch2_high_sel (ch2_high_sel),
        .coeff_q      (coeff_q),
        .sel_q        (sel_q)
    );

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic end_of_test;
        if (n_fail == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Strobe held through exactly one sampling edge
    task automatic wr(input logic [7:0] a, input logic [23:0] d);
        @(posedge mclk);
        #1;
        reg_wr_en = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge mclk);
        #1;
        reg_wr_en = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [23:0] e, input logic h);
        @(posedge mclk);
        #1;
        reg_rd_en = 1'b1;
        reg_addr = a;
        @(posedge mclk);
        #1;
        reg_rd_en = 1'b0;
        `CHK("rvalid", 1'b1, reg_rvalid_q)
        `CHK("rdata", e, reg_rdata_q)
        `CHK("hit", h, reg_hit_q)
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        n_fail++;
        end_of_test();
    end

    initial begin
        n_fail = 0;
        n_compared = 0;
        rst_n = 1'b0;
        ce = 1'b1;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 24'h00_0000;
        ch2_high_sel = 1'b1;
        repeat (8) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        `CHK("coeff_rst", 112'h0, coeff_q)
        `CHK("sel_rst", 80'h0, sel_q)
        for (int i = 0; i < 7; i++) rd(rows[i].addr, 24'h00_0000, rows[i].hit);
        @(posedge mclk);
        #1;
        `CHK("rvalid_drop", 1'b0, reg_rvalid_q)
        // Table: all writes first, then all reads
        for (int i = 0; i < 7; i++) wr(rows[i].addr, rows[i].wdata);
        for (int i = 0; i < 7; i++) rd(rows[i].addr, rows[i].rdata, rows[i].hit);
        `CHK("q_ch1_hi", 16'h1278, coeff_q.quartic_coeff_ch1_high)
        `CHK("sq_ch1_hi", 16'h3456, coeff_q.quadratic_coeff_ch1_high)
        `CHK("sq_ch2_lo", 16'h9ABC, coeff_q.quadratic_coeff_ch2_low)
        `CHK("q_ch2_lo", 16'hDE34, coeff_q.quartic_coeff_ch2_low)
        `CHK("sq_ch2_hi", 16'hF012, coeff_q.quadratic_coeff_ch2_high)
        `CHK("cu_ch0_hi", 16'h5678, coeff_q.cubic_coeff_ch0_high)
        `CHK("q_ch2_hi", 16'h4321, coeff_q.quartic_coeff_ch2_high)
        // Channel selection by current setting
        `CHK("sel_ch0", 16'h5678, sel_q.cubic_ch0)
        `CHK("sel_ch1", 32'h3456_1278, sel_q.ch1)
        `CHK("sel_ch2_hi", 32'hF012_4321, sel_q.ch2)
        ch2_high_sel = 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        `CHK("sel_ch2_lo", 32'h9ABC_DE34, sel_q.ch2)
        // Read and write together: old value comes back, new one lands
        @(posedge mclk);
        #1;
        reg_rd_en = 1'b1;
        reg_wr_en = 1'b1;
        reg_addr = 8'hAE;
        reg_wdata = 24'hAA_5555;
        @(posedge mclk);
        #1;
        reg_rd_en = 1'b0;
        reg_wr_en = 1'b0;
        `CHK("rw_old", 24'h12_3456, reg_rdata_q)
        // Only AE was written, so the split quartic changes in its upper byte alone
        `CHK("q_ch1_split", 16'hAA78, coeff_q.quartic_coeff_ch1_high)
        `CHK("sq_ch1_new", 16'h5555, coeff_q.quadratic_coeff_ch1_high)
        // Clock enable low drops the write
        ce = 1'b0;
        wr(8'hB1, 24'h00_0000);
        ce = 1'b1;
        rd(8'hB1, 24'h34_5678, 1'b1);
        // Back-to-back strobes: B0, B1, B2 writes, then B2 read at once
        @(posedge mclk);
        #1;
        reg_wr_en = 1'b1;
        reg_addr = 8'hB0;
        reg_wdata = 24'h11_2222;
        @(posedge mclk);
        #1;
        reg_addr = 8'hB1;
        reg_wdata = 24'h33_4444;
        @(posedge mclk);
        #1;
        reg_addr = 8'hB2;
        reg_wdata = 24'h00_5566;
        @(posedge mclk);
        #1;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b1;
        @(posedge mclk);
        #1;
        reg_rd_en = 1'b0;
        `CHK("b2_b2b", 24'h00_5566, reg_rdata_q)
        `CHK("q_ch2_lo_b2b", 16'h1133, coeff_q.quartic_coeff_ch2_low)
        `CHK("cu_ch0_b2b", 16'h4444, coeff_q.cubic_coeff_ch0_high)
        // Second reset mid-run clears the whole bank
        rst_n = 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        `CHK("coeff_rst2", 112'h0, coeff_q)
        `CHK("sel_rst2", 80'h0, sel_q)
        `CHK("rdata_rst2", 24'h00_0000, reg_rdata_q)
        rst_n = 1'b1;
        rd(8'hB2, 24'h00_0000, 1'b1);
        end_of_test();
    end
endmodule
